/* File: design/two_wire_master.sv */
// Purpose: Master side of a two-wire serial controller
// Assumes: Commands are one-cycle pulses on clk_i; lines pulled up outside
// Notes: Lines are open drain, only ever pulled low
// Operation
// R1: Master starts each transfer, makes the serial clock and ends it.
// R2: Software sets address, sizes and dividers, then enables master role.
// R3: Holding write starts: start, 7-bit address, direction bit zero.
// R4: Ninth pulse releases data, samples it; high sets not-acknowledge flag.
// R5: Any status flag raises the interrupt when its enable bit is set.
// R6: On acknowledge, held byte moves to shifter and transmit-ready sets.
// R7: Transmit-ready is also the transmit DMA request.
// R8: With no new byte, clock held low until write or stop.
// R9: Stop only follows the stop command; code also stops after a not-acknowledge or a quick command.
// R10: Start command sends start, 7-bit address, direction one, then acknowledge.
// R11: Master acknowledges each received byte, not the last, then stops.
// R12: Receive-ready sets on byte arrival, clears on holding register read.
// R13: Software sets start with stop for one byte, else stop before last.
// R14: Receive-ready is also the receive DMA request.
// R15: Read with internal address writes it, repeated start, then receives.
// R16: Internal address size selects zero to three bytes; zero sends none.
// R17: Ten-bit slaves use size one, prefix 11110 and low byte in register.
// R18: Upper internal address bytes stay usable with ten-bit addressing.
// R19: Software drives DMA transmit ending: wait, stop, write last byte.
// R20: Software sizes receive DMA as buffer minus two, reads last two.
// R21: Quick command sends address with mode direction bit, then stops.
// R22: Transfer-complete flag sets once the transfer has fully finished.
// R23: Start is data falling while clock high; stop is data rising.
// R24: Bytes are eight bits, most significant first, each then acknowledged.
// R25: Clock low and high times come from divider fields.
// R26: Both lines only pulled low, never driven high.
`timescale 1ns/1ps
`default_nettype none

module two_wire_master (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Configuration
  input wire twm_pkg::cfg_t cfg_i,
  input wire logic master_role_enable_i,
  input wire logic slave_role_disable_i,
  input wire twm_pkg::flags_t interrupt_enable_i,
  // Commands
  input wire twm_pkg::cmd_t cmd_i,
  // Status
  output twm_pkg::flags_t status_o,
  output logic [7:0] receive_holding_o,
  output logic irq_o,
  output logic dma_tx_req_o,
  output logic dma_rx_req_o,
  // Serial lines
  input wire logic serial_clock_line_i,
  output logic serial_clock_line_o,
  output logic serial_clock_line_oe_n_o,
  input wire logic serial_data_line_i,
  output logic serial_data_line_o,
  output logic serial_data_line_oe_n_o
);

  // ==========================================================
  // Helpers
  function automatic logic [15:0] phase_len(input logic [7:0] div,
                                            input logic [2:0] pre);
    phase_len = ({8'h00, div} << pre) + twm_pkg::PHASE_BASE;
  endfunction

  function automatic logic [7:0] internal_addr_value_byte(input logic [23:0] val,
                                           input logic [1:0] idx);
    internal_addr_value_byte = val[{idx - 2'h1, 3'h0} +: 8];
  endfunction

  function automatic logic bit_pull(input twm_pkg::state_t t);
    if (t.bitcnt == twm_pkg::ACK_BIT) begin
      bit_pull = (t.kind == twm_pkg::K_RX) && !t.last;
    end else begin
      bit_pull = (t.kind != twm_pkg::K_RX) && !t.shift[7];
    end
  endfunction

  // ==========================================================
  // Line synchronisers and phase timer
  logic [1:0] lines_s;
  logic scl_s;
  logic sda_s;
  logic tmr_load;
  logic [15:0] tmr_count;
  logic tmr_done;

  two_flop_sync u_sync (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .async_i({serial_clock_line_i, serial_data_line_i}),
    .sync_o(lines_s)
  );

  assign scl_s = lines_s[1];
  assign sda_s = lines_s[0];

  phase_timer u_timer (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .load_i(tmr_load),
    .count_i(tmr_count),
    .done_o(tmr_done)
  );

  // ==========================================================
  // Sequencer
  twm_pkg::state_t s_r;
  twm_pkg::state_t s_nxt;
  logic master_on;
  logic need_high;
  logic is_low;
  logic phase_end;
  logic [15:0] t_low;
  logic [15:0] t_high;

  assign master_on = master_role_enable_i && slave_role_disable_i;
  assign t_low = phase_len(cfg_i.clock_low_div, cfg_i.clock_prescale_div); // R25
  assign t_high = phase_len(cfg_i.clock_high_div, cfg_i.clock_prescale_div); // R25

  always_comb begin
    s_nxt = s_r;
    tmr_load = 1'b0;
    tmr_count = 16'h0000;
    phase_end = 1'b0;
    need_high = s_r.st inside {twm_pkg::ST_BIT_HIGH, twm_pkg::ST_STOP_HIGH,
                               twm_pkg::ST_RS_HIGH};
    is_low = s_r.st inside {twm_pkg::ST_BIT_LOW, twm_pkg::ST_STOP_LOW,
                            twm_pkg::ST_RS_LOW};
    if (cmd_i.stop) begin
      s_nxt.stop_req = 1'b1;
    end
    if (cmd_i.thr_write) begin
      s_nxt.thr = cmd_i.thr_data;
      s_nxt.thr_full = 1'b1;
      s_nxt.flags.transmit_ready_flag = 1'b0;
    end
    if (cmd_i.rhr_read) begin
      s_nxt.flags.receive_ready_flag = 1'b0; // R12
    end
    if (cmd_i.status_read) begin
      s_nxt.flags.nack = 1'b0;
    end
    // Timed phases; high phases wait out slave clock stretching
    if (!(s_r.st inside {twm_pkg::ST_IDLE, twm_pkg::ST_HOLD})) begin
      if (!s_r.armed) begin
        if (!need_high || scl_s) begin
          tmr_load = 1'b1;
          tmr_count = is_low ? t_low : t_high; // R25
          s_nxt.armed = 1'b1;
        end
      end else if (tmr_done) begin
        s_nxt.armed = 1'b0;
        phase_end = 1'b1;
      end
    end
    unique case (s_r.st)
      twm_pkg::ST_IDLE: begin
        s_nxt.stop_req = cmd_i.stop;
        if (master_on && (cmd_i.thr_write || cmd_i.start || cmd_i.quick)) begin // R1 R3
          s_nxt.st = twm_pkg::ST_START;
          s_nxt.armed = 1'b0;
          s_nxt.flags.transfer_complete_flag = 1'b0;
          s_nxt.kind = twm_pkg::K_ADDR;
          s_nxt.bitcnt = twm_pkg::FIRST_BIT;
          s_nxt.quick = cmd_i.quick;
          s_nxt.iacnt = cmd_i.quick ? twm_pkg::INTERNAL_ADDR_VALUE_NONE
                                    : cfg_i.internal_addr_size; // R16
          s_nxt.read_xfer = cmd_i.start && !cmd_i.quick && cfg_i.direction_read_bit;
          s_nxt.addr_rd = s_nxt.read_xfer &&
                          (cfg_i.internal_addr_size == twm_pkg::INTERNAL_ADDR_VALUE_NONE); // R10 R15
          if (cmd_i.quick) begin
            s_nxt.shift = {cfg_i.target_device_address, cfg_i.direction_read_bit}; // R21
          end else begin
            s_nxt.shift = {cfg_i.target_device_address,
                           s_nxt.addr_rd ? twm_pkg::DIR_READ : twm_pkg::DIR_WRITE}; // R3 R10
          end
        end
      end
      twm_pkg::ST_START: begin
        if (phase_end) begin
          s_nxt.st = twm_pkg::ST_BIT_LOW;
        end
      end
      twm_pkg::ST_BIT_LOW: begin
        if (phase_end) begin
          s_nxt.st = twm_pkg::ST_BIT_HIGH;
        end
      end
      twm_pkg::ST_BIT_HIGH: begin
        if (phase_end && s_r.bitcnt != twm_pkg::ACK_BIT) begin
          s_nxt.shift = {s_r.shift[6:0], sda_s}; // R24
          s_nxt.bitcnt = s_r.bitcnt + 4'h1;
          s_nxt.st = twm_pkg::ST_BIT_LOW;
          if (s_r.kind == twm_pkg::K_RX && s_r.bitcnt == twm_pkg::LAST_DATA_BIT) begin
            s_nxt.rhr = {s_r.shift[6:0], sda_s}; // R12
            s_nxt.flags.receive_ready_flag = 1'b1; // R12
            s_nxt.last = s_r.stop_req; // R11
          end
        end else if (phase_end) begin
          s_nxt.bitcnt = twm_pkg::FIRST_BIT;
          if (s_r.kind == twm_pkg::K_RX) begin
            s_nxt.st = s_r.last ? twm_pkg::ST_STOP_LOW : twm_pkg::ST_BIT_LOW; // R11
          end else if (sda_s) begin
            s_nxt.flags.nack = 1'b1; // R4
            s_nxt.st = twm_pkg::ST_STOP_LOW;
          end else if (s_r.quick) begin
            s_nxt.st = twm_pkg::ST_STOP_LOW; // R21
          end else if (s_r.kind == twm_pkg::K_ADDR && s_r.addr_rd) begin
            s_nxt.kind = twm_pkg::K_RX; // R10
            s_nxt.last = s_r.stop_req;
            s_nxt.st = twm_pkg::ST_BIT_LOW;
          end else if (s_r.iacnt != twm_pkg::INTERNAL_ADDR_VALUE_NONE) begin
            s_nxt.kind = twm_pkg::K_INTERNAL_ADDR_VALUE; // R16 R18
            s_nxt.shift = internal_addr_value_byte(cfg_i.internal_addr_value, s_r.iacnt);
            s_nxt.iacnt = s_r.iacnt - 2'h1;
            s_nxt.st = twm_pkg::ST_BIT_LOW;
          end else if (s_r.read_xfer) begin
            s_nxt.st = twm_pkg::ST_RS_LOW; // R15
          end else if (s_r.thr_full) begin
            s_nxt.kind = twm_pkg::K_TX;
            s_nxt.shift = s_r.thr; // R6
            s_nxt.thr_full = cmd_i.thr_write;
            s_nxt.flags.transmit_ready_flag = 1'b1; // R6 R7
            s_nxt.st = twm_pkg::ST_BIT_LOW;
          end else begin
            s_nxt.kind = twm_pkg::K_TX;
            s_nxt.flags.transmit_ready_flag = 1'b1; // R6
            s_nxt.st = twm_pkg::ST_HOLD; // R8
          end
        end
      end
      twm_pkg::ST_HOLD: begin
        if (s_r.thr_full) begin
          s_nxt.shift = s_r.thr; // R8
          s_nxt.thr_full = cmd_i.thr_write;
          s_nxt.flags.transmit_ready_flag = 1'b1;
          s_nxt.armed = 1'b0;
          s_nxt.st = twm_pkg::ST_BIT_LOW;
        end else if (s_r.stop_req) begin
          s_nxt.armed = 1'b0;
          s_nxt.st = twm_pkg::ST_STOP_LOW; // R8 R9
        end
      end
      twm_pkg::ST_STOP_LOW: begin
        if (phase_end) begin
          s_nxt.st = twm_pkg::ST_STOP_HIGH;
        end
      end
      twm_pkg::ST_STOP_HIGH: begin
        if (phase_end) begin
          s_nxt.st = twm_pkg::ST_STOP_END; // R23
        end
      end
      twm_pkg::ST_STOP_END: begin
        if (phase_end) begin
          s_nxt.st = twm_pkg::ST_IDLE;
          s_nxt.stop_req = cmd_i.stop;
          s_nxt.quick = 1'b0;
          s_nxt.flags.transfer_complete_flag = 1'b1; // R22
        end
      end
      twm_pkg::ST_RS_LOW: begin
        if (phase_end) begin
          s_nxt.st = twm_pkg::ST_RS_HIGH;
        end
      end
      twm_pkg::ST_RS_HIGH: begin
        if (phase_end) begin
          s_nxt.st = twm_pkg::ST_START; // R15
          s_nxt.kind = twm_pkg::K_ADDR;
          s_nxt.addr_rd = 1'b1;
          s_nxt.shift = {cfg_i.target_device_address, twm_pkg::DIR_READ}; // R10
        end
      end
      default: begin
        s_nxt.st = twm_pkg::ST_IDLE;
        s_nxt.armed = 1'b0;
      end
    endcase
    // Line pulls follow the next state
    s_nxt.scl_drv = s_nxt.st inside {twm_pkg::ST_BIT_LOW, twm_pkg::ST_HOLD,
                                     twm_pkg::ST_STOP_LOW, twm_pkg::ST_RS_LOW}; // R1 R8
    unique case (s_nxt.st)
      twm_pkg::ST_START, twm_pkg::ST_STOP_LOW, twm_pkg::ST_STOP_HIGH: begin
        s_nxt.sda_drv = 1'b1; // R23
      end
      twm_pkg::ST_BIT_LOW, twm_pkg::ST_BIT_HIGH: begin
        s_nxt.sda_drv = bit_pull(s_nxt); // R4 R11 R24
      end
      default: begin
        s_nxt.sda_drv = 1'b0;
      end
    endcase
    // Data moves one cycle after the clock falls, so no false start or stop
    if (s_nxt.st inside {twm_pkg::ST_BIT_LOW, twm_pkg::ST_STOP_LOW} && s_nxt.st != s_r.st) begin
      s_nxt.sda_drv = s_r.sda_drv; // R23
    end
    s_nxt.irq = |(s_nxt.flags & interrupt_enable_i); // R5
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_r <= '0;
      s_r.st <= twm_pkg::ST_IDLE;
      s_r.kind <= twm_pkg::K_ADDR;
      s_r.flags <= twm_pkg::FLAGS_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign status_o = s_r.flags;
  assign receive_holding_o = s_r.rhr;
  assign irq_o = s_r.irq;
  assign dma_tx_req_o = s_r.flags.transmit_ready_flag; // R7
  assign dma_rx_req_o = s_r.flags.receive_ready_flag; // R14
  assign serial_clock_line_o = 1'b0; // R26
  assign serial_data_line_o = 1'b0; // R26
  assign serial_clock_line_oe_n_o = !s_r.scl_drv; // R26
  assign serial_data_line_oe_n_o = !s_r.sda_drv; // R26

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  nack_flag_set_a: assert property ( // R4
    (s_r.st == twm_pkg::ST_BIT_HIGH && phase_end && s_r.kind != twm_pkg::K_RX
     && s_r.bitcnt == twm_pkg::ACK_BIT && sda_s) |=> s_r.flags.nack
  ) else $error("not-acknowledge flag missed");

  ack_release_a: assert property ( // R4
    (s_r.st == twm_pkg::ST_BIT_HIGH && s_r.kind != twm_pkg::K_RX
     && s_r.bitcnt == twm_pkg::ACK_BIT) |-> serial_data_line_oe_n_o
  ) else $error("data line held during acknowledge");

  irq_gate_a: assert property ( // R5
    ##1 (irq_o == |(status_o & $past(interrupt_enable_i)))
  ) else $error("interrupt line disagrees with flags");

  hold_clock_low_a: assert property ( // R8
    (s_r.st == twm_pkg::ST_HOLD && !s_r.thr_full && !s_r.stop_req)
    |=> !serial_clock_line_oe_n_o && s_r.st == twm_pkg::ST_HOLD
  ) else $error("clock released with empty holding register");

  stop_cause_a: assert property ( // R9
    $rose(s_r.st == twm_pkg::ST_STOP_LOW)
    |-> $past(s_r.stop_req || s_r.quick || sda_s || s_r.last)
  ) else $error("stop without a cause");

  rx_byte_land_a: assert property ( // R12
    (s_r.st == twm_pkg::ST_BIT_HIGH && phase_end && s_r.kind == twm_pkg::K_RX
     && s_r.bitcnt == twm_pkg::LAST_DATA_BIT)
    |=> s_r.flags.receive_ready_flag && receive_holding_o == $past({s_r.shift[6:0], sda_s})
  ) else $error("received byte not posted");

  rx_ack_drive_a: assert property ( // R11
    (s_r.st == twm_pkg::ST_BIT_HIGH && s_r.kind == twm_pkg::K_RX
     && s_r.bitcnt == twm_pkg::ACK_BIT) |-> (serial_data_line_oe_n_o == s_r.last)
  ) else $error("wrong acknowledge on received byte");

  start_shape_a: assert property ( // R23
    (s_r.st == twm_pkg::ST_START) |-> !serial_data_line_oe_n_o && serial_clock_line_oe_n_o
  ) else $error("start condition malformed");

  msb_first_a: assert property ( // R24
    (s_r.st == twm_pkg::ST_BIT_LOW && s_r.armed && s_r.kind != twm_pkg::K_RX
     && s_r.bitcnt != twm_pkg::ACK_BIT) |-> (serial_data_line_oe_n_o == s_r.shift[7])
  ) else $error("data bit does not match shifter");

  done_flag_a: assert property ( // R22
    $rose(s_r.flags.transfer_complete_flag) |-> $past(s_r.st == twm_pkg::ST_STOP_END) && s_r.st == twm_pkg::ST_IDLE
  ) else $error("complete flag outside stop end");

endmodule // two_wire_master

`default_nettype wire

/* File: design/twm_pkg.sv */
// Purpose: Shared types and constants of the two-wire master controller
// Assumes: One system clock, active-low asynchronous reset
// Notes: Phase lengths are (divider << prescale) + base cycles
`default_nettype none

package twm_pkg;

  // ==========================================================
  // Timing and bit positions
  localparam logic [15:0] PHASE_BASE = 16'h0004;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] FIRST_BIT = 4'h0;
  localparam logic [1:0] INTERNAL_ADDR_VALUE_NONE = 2'h0;
  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ = 1'b1;

  // ==========================================================
  // Bus sequencer states
  typedef enum logic [9:0] {
    ST_IDLE      = 10'h001,
    ST_START     = 10'h002,
    ST_BIT_LOW   = 10'h004,
    ST_BIT_HIGH  = 10'h008,
    ST_HOLD      = 10'h010,
    ST_STOP_LOW  = 10'h020,
    ST_STOP_HIGH = 10'h040,
    ST_STOP_END  = 10'h080,
    ST_RS_LOW    = 10'h100,
    ST_RS_HIGH   = 10'h200
  } st_t;

  // Byte kinds on the wire
  typedef enum logic [3:0] {
    K_ADDR = 4'h1,
    K_INTERNAL_ADDR_VALUE = 4'h2,
    K_TX   = 4'h4,
    K_RX   = 4'h8
  } kind_t;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [6:0] target_device_address;
    logic [1:0] internal_addr_size;
    logic [23:0] internal_addr_value;
    logic direction_read_bit;
    logic [2:0] clock_prescale_div;
    logic [7:0] clock_high_div;
    logic [7:0] clock_low_div;
  } cfg_t;

  typedef struct packed {
    logic start;
    logic stop;
    logic quick;
    logic thr_write;
    logic [7:0] thr_data;
    logic rhr_read;
    logic status_read;
  } cmd_t;

  typedef struct packed {
    logic nack;
    logic transfer_complete_flag;
    logic transmit_ready_flag;
    logic receive_ready_flag;
  } flags_t;

  localparam flags_t FLAGS_RST = 4'h4;

  typedef struct packed {
    st_t st;
    kind_t kind;
    logic armed;
    logic [3:0] bitcnt;
    logic [7:0] shift;
    logic [7:0] thr;
    logic thr_full;
    logic [1:0] iacnt;
    logic read_xfer;
    logic addr_rd;
    logic quick;
    logic stop_req;
    logic last;
    logic [7:0] rhr;
    flags_t flags;
    logic scl_drv;
    logic sda_drv;
    logic irq;
  } state_t;

endpackage

`default_nettype wire

/* File: design/two_flop_sync.sv */
// Purpose: Two-stage synchroniser for the bus line levels
// Assumes: Inputs are asynchronous to clk_i
// Notes: Lines idle high, so both stages reset high
`timescale 1ns/1ps
`default_nettype none

module two_flop_sync (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Lines
  input wire logic [1:0] async_i,
  output logic [1:0] sync_o
);

  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] stable;
  } sync_t;

  sync_t s_r;
  sync_t s_nxt;

  always_comb begin
    s_nxt.meta = async_i;
    s_nxt.stable = s_r.meta;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_r <= '1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sync_o = s_r.stable;

endmodule // two_flop_sync

`default_nettype wire

/* File: design/phase_timer.sv */
// Purpose: Down counter timing one half period of the serial clock
// Assumes: load_i is a one-cycle pulse with a count of at least one
// Notes: done_o is high once the count has run out
`timescale 1ns/1ps
`default_nettype none

module phase_timer (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Control
  input wire logic load_i,
  input wire logic [15:0] count_i,
  output logic done_o
);

  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (load_i) begin
      cnt_nxt = count_i;
    end else if (cnt_r != 16'h0000) begin
      cnt_nxt = cnt_r - 16'h0001;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_r <= 16'h0000;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign done_o = (cnt_r == 16'h0000) && !load_i;

endmodule // phase_timer

`default_nettype wire

/* File: verif/two_wire_slave_model.sv */
// Purpose: Behavioural two-wire slave facing the master controller
// Assumes: Lines resolved in the bench, a released line reads high
// Notes: Acknowledge refusal and clock stretch only on command
`timescale 1ns/1ps
`default_nettype none

module two_wire_slave_model (
  // Resolved lines
  input wire logic scl_i,
  input wire logic sda_i,
  // Pull-downs
  output logic scl_oe_n_o,
  output logic sda_oe_n_o,
  // Behaviour
  input wire logic nack_i,
  input wire logic stretch_i
);
  logic [7:0] sh;
  logic [7:0] tx;
  logic [7:0] rx_q[$];
  logic [7:0] tx_q[$];
  logic mack_q[$];
  logic first;
  logic rd;
  logic mk;
  int cnt;
  int nst;
  int nsp;

  initial begin
    scl_oe_n_o = 1'b1;
    sda_oe_n_o = 1'b1;
    {first, rd, mk, cnt, nst, nsp} = '0;
  end

  // ==========================================
  // Conditions and bits
  always @(negedge sda_i) if (scl_i) begin
    {cnt, first, rd, mk} = {32'h0, 3'h4};
    nst++;
  end
  always @(posedge sda_i) if (scl_i) nsp++;
  always @(posedge scl_i) begin
    if (cnt < 8) sh = {sh[6:0], sda_i};
    else if (rd && !first) begin
      mk = sda_i;
      mack_q.push_back(sda_i);
    end
    cnt++;
  end
  always @(negedge scl_i) begin
    if (cnt == 8) begin
      sda_oe_n_o = 1'b1;
      if (first || !rd) begin
        rx_q.push_back(sh);
        if (first) rd = sh[0];
        sda_oe_n_o = nack_i;
      end
    end else if (cnt == 9) begin
      cnt = 0;
      first = 1'b0;
      sda_oe_n_o = 1'b1;
      if (rd && !mk && tx_q.size() > 0) begin
        tx = tx_q.pop_front();
        sda_oe_n_o = tx[7];
      end
      if (stretch_i) begin
        scl_oe_n_o = 1'b0;
        #240 scl_oe_n_o = 1'b1;
      end
    end else if (rd && !first && cnt < 8) sda_oe_n_o = tx[7 - cnt];
  end
endmodule // two_wire_slave_model

`default_nettype wire

/* File: verif/two_wire_master_controller_test.sv */
// Purpose: Self-checking bench of the two-wire master controller
// Assumes: Slave model on the far side, pull-ups on both lines
// Notes: Dividers at zero keep each bit short
`timescale 1ns/1ps
`default_nettype none

module two_wire_master_controller_test;
  localparam logic [13:0] C_START = 14'h2000;
  localparam logic [13:0] C_STOP = 14'h1000;
  localparam logic [13:0] C_QUICK = 14'h0800;
  localparam logic [13:0] C_THR = 14'h0400;
  localparam logic [13:0] C_RHR = 14'h0002;
  localparam logic [13:0] C_SR = 14'h0001;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic men = 1'b1;
  logic sdis = 1'b1;
  logic nak = 1'b0;
  logic strt = 1'b0;
  twm_pkg::cfg_t cfg = '0;
  twm_pkg::cmd_t cmd = '0;
  twm_pkg::flags_t ien = '0;
  twm_pkg::flags_t st;
  logic [7:0] rhr;
  logic irq, txq, rxq, sclo, sdao, scl_m, sda_m, scl_s, sda_s;
  logic [31:0] seed = 32'h0000002f;
  logic [7:0] exp_q[$];
  int error_cnt = 0;
  int comparisons = 0;
  wire scl = scl_m & scl_s;
  wire sda = sda_m & sda_s;

  always #4 clk = ~clk;

  two_wire_master u_dut (.clk_i(clk), .resetn_i(resetn), .cfg_i(cfg),
    .master_role_enable_i(men), .slave_role_disable_i(sdis), .interrupt_enable_i(ien),
    .cmd_i(cmd), .status_o(st), .receive_holding_o(rhr), .irq_o(irq),
    .dma_tx_req_o(txq), .dma_rx_req_o(rxq), .serial_clock_line_i(scl),
    .serial_clock_line_o(sclo), .serial_clock_line_oe_n_o(scl_m),
    .serial_data_line_i(sda), .serial_data_line_o(sdao), .serial_data_line_oe_n_o(sda_m));
  two_wire_slave_model u_slv (.scl_i(scl), .sda_i(sda), .scl_oe_n_o(scl_s),
    .sda_oe_n_o(sda_s), .nack_i(nak), .stretch_i(strt));

  // ==========================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input bit ok, input string m);
    comparisons++;
    if (!ok) begin
      error_cnt++;
      $display("unexpected %0t %s", $time, m);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pulse(input logic [13:0] v);
    cmd = twm_pkg::cmd_t'(v);
    cyc(1);
    cmd = '0;
  endtask
  task automatic wait_st(input int b, input logic v);
    int k;
    k = 0;
    while (st[b] !== v && k < 5000) begin
      cyc(1);
      k++;
    end
    if (k == 5000) chk(1'b0, "flag wait");
  endtask
  task automatic prep(input int s, input logic d);
    logic [31:0] t;
    t = rnd();
    cfg.internal_addr_size = s[1:0];
    cfg.direction_read_bit = d;
    cfg.target_device_address = (s == 1) ? {5'h1e, t[1:0]} : t[6:0];
    cfg.internal_addr_value = t[31:8];
    strt = t[7];
    u_slv.rx_q = {};
    u_slv.mack_q = {};
    u_slv.nst = 0;
    u_slv.nsp = 0;
    exp_q = {};
    exp_q.push_back({cfg.target_device_address, 1'b0});
    for (int i = s - 1; i >= 0; i--) exp_q.push_back(cfg.internal_addr_value[8 * i +: 8]);
  endtask
  task automatic fin(input int ns);
    wait_st(2, 1'b1);
    chk(u_slv.rx_q.size() == exp_q.size(), "byte count");
    foreach (exp_q[i]) chk(u_slv.rx_q[i] === exp_q[i], "wire byte");
    chk(u_slv.nst == ns && u_slv.nsp == 1, "start stop count");
    chk(scl === 1'b1 && sda === 1'b1 && sclo === 1'b0 && sdao === 1'b0, "idle lines");
  endtask
  task automatic rd(input int s, input int n);
    logic [7:0] b[$];
    logic [31:0] t;
    b = {};
    prep(s, 1'b1);
    if (s == 0) exp_q[0][0] = 1'b1;
    else exp_q.push_back({cfg.target_device_address, 1'b1});
    for (int i = 0; i < n; i++) begin
      t = rnd();
      b.push_back(t[7:0]);
      u_slv.tx_q.push_back(t[7:0]);
    end
    pulse(n == 1 ? (C_START | C_STOP) : C_START);
    for (int i = 0; i < n; i++) begin
      wait_st(0, 1'b1);
      chk(rhr === b[i] && rxq === 1'b1, "read byte");
      pulse(i == n - 2 ? (C_RHR | C_STOP) : C_RHR);
      chk(st.receive_ready_flag === 1'b0, "receive_ready_flag clear");
    end
    fin(s > 0 ? 2 : 1);
    foreach (b[i]) chk(u_slv.mack_q[i] === (i == n - 1), "master ack");
  endtask
  task automatic give_verdict();
    if (error_cnt == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ==========================================
  // Sequence
  initial begin
    logic [7:0] d0;
    logic [7:0] d1;
    cyc(8);
    resetn = 1'b1;
    chk(st === twm_pkg::FLAGS_RST && irq === 1'b0 && rhr === 8'h00, "reset flags");
    chk(scl_m === 1'b1 && sda_m === 1'b1, "reset lines");
    cyc(3);
    men = 1'b0;
    pulse(C_START);
    cyc(40);
    chk(st.transfer_complete_flag === 1'b1 && sda_m === 1'b1 && scl_m === 1'b1, "role off");
    men = 1'b1;
    for (int s = 0; s < 4; s++) begin
      prep(s, 1'b0);
      d0 = 8'(rnd());
      d1 = 8'(rnd());
      exp_q.push_back(d0);
      pulse(C_THR | {4'h0, d0, 2'h0});
      wait_st(1, 1'b1);
      chk(txq === 1'b1, "tx request");
      cyc(1000);
      chk(scl === 1'b0 && st.transfer_complete_flag === 1'b0 && u_slv.rx_q.size() == s + 2, "hold");
      pulse(C_THR | {4'h0, d1, 2'h0});
      pulse(C_STOP);
      exp_q.push_back(d1);
      fin(1);
    end
    for (int d = 0; d < 2; d++) begin
      prep(0, d[0]);
      exp_q[0][0] = d[0];
      pulse(C_QUICK);
      wait_st(2, 1'b0);
      fin(1);
    end
    rd(0, 1);
    rd(2, 2);
    rd(0, 3);
    prep(0, 1'b0);
    nak = 1'b1;
    ien = 4'h8;
    pulse(C_THR | 14'h0168);
    wait_st(3, 1'b1);
    fin(1);
    chk(irq === 1'b1, "irq on nack");
    ien = 4'h0;
    cyc(3);
    chk(irq === 1'b0, "irq masked");
    pulse(C_SR);
    chk(st.nack === 1'b0, "nack clear");
    ien = 4'h4;
    cyc(3);
    chk(irq === 1'b1, "irq on complete");
    give_verdict();
  end

  initial begin
    #400000;
    error_cnt++;
    give_verdict();
  end
endmodule // two_wire_master_controller_test

`default_nettype wire
